//--- hdl/iad_pkg.sv
// constants and types of the address decode and auto-increment front end
//
// Function
// - ack every control and data byte when addressed; soft reset keys only on match
// - on master nack, release data line high
// - address byte bit 0 selects read
// - broadcast address defaults 90h, enabled
// - three group addresses 92h/94h/98h, disabled
// - soft reset address acked for write only
// - first written byte loads control register
// - control bits 4:0 pointer, 7:5 options
// - option top bit set advances pointer
// - options 000 keep pointer fixed
// - options 100 wrap 11h to 00h
// - options 101 wrap 09h to 02h
// - options 110 wrap 0Bh to 0Ah
// - options 111 wrap 0Bh to 02h
// - stepping never reaches 12h or 13h
// - stepping changes only pointer field
// - first access uses written pointer
// - pointer above range climbs to 11h, wraps, cycles; 12h and up wraps to 00h at once
// - soft reset needs A5h, 5Ah, stop
// - group and broadcast responses gated by enables
// - brightness 02h-09h, duty 0Ah, period 0Bh

package iad_pkg;

   // ****************************************************************
   // register pointers
   // ****************************************************************
   localparam logic [4:0] PTR_MODE = 5'h00;
   localparam logic [4:0] PTR_ALL_FIRST = 5'h00;
   localparam logic [4:0] PTR_BRIGHT_FIRST = 5'h02;
   localparam logic [4:0] PTR_BRIGHT_LAST = 5'h09;
   localparam logic [4:0] PTR_GROUP_DUTY = 5'h0a;
   localparam logic [4:0] PTR_GROUP_PERIOD = 5'h0b;
   localparam logic [4:0] PTR_GRP1 = 5'h0e;
   localparam logic [4:0] PTR_BCAST = 5'h11;
   localparam logic [4:0] PTR_FAULT = 5'h13;

   // ****************************************************************
   // control byte layout and option codes
   // ****************************************************************
   localparam int CTRL_PTR_MSB = 4;
   localparam int INCR_ENABLE_BIT = 7;
   localparam int INCR_OPTION_LO = 5;
   localparam logic [1:0] OPT_ALL = 2'h0;
   localparam logic [1:0] OPT_BRIGHT = 2'h1;
   localparam logic [1:0] OPT_GROUP = 2'h2;
   localparam logic [1:0] OPT_BRIGHT_GROUP = 2'h3;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // ****************************************************************
   // primary mode register: low five bits held here
   // ****************************************************************
   localparam logic [4:0] MODE_RST = 5'h11;
   localparam int MODE_GRP1_BIT = 3;

   // ****************************************************************
   // bus addresses and soft reset keys
   // ****************************************************************
   localparam int N_ADDR_REGS = 4;
   localparam logic [7:0] GRP1_ADDR_RST = 8'h92;
   localparam logic [7:0] GRP2_ADDR_RST = 8'h94;
   localparam logic [7:0] GRP3_ADDR_RST = 8'h98;
   localparam logic [7:0] BCAST_ADDR_RST = 8'h90;
   localparam logic [3:0][7:0] ADDR_RST =
      {BCAST_ADDR_RST, GRP3_ADDR_RST, GRP2_ADDR_RST, GRP1_ADDR_RST};
   localparam logic [7:0] SOFT_RESET_CALL = 8'h96;
   localparam logic [7:0] SOFT_KEY1 = 8'ha5;
   localparam logic [7:0] SOFT_KEY2 = 8'h5a;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK
   } iad_state_t;

   typedef enum logic [2:0] {
      K_ADDR, K_CTRL, K_DATA, K_RST1, K_RST2, K_RST_DONE
   } iad_kind_t;

endpackage

//--- hdl/iad_step_if.sv
// pointer stepping signals between the front end and its stepper
`timescale 1ns/100ps
interface iad_step_if;
   logic [4:0] ptr;
   logic [2:0] opt;
   logic [4:0] nxt;
   modport stepper (input ptr, input opt, output nxt);
   modport user (output ptr, output opt, input nxt);
endinterface

//--- hdl/iad_ptr_step.sv
// next register pointer for each auto-increment option
`timescale 1ns/100ps
module iad_ptr_step
   import iad_pkg::*;
(
   iad_step_if.stepper step
);

   logic [4:0] first;
   logic [4:0] last;

   // ****************************************************************
   // wrap range of the selected option
   // ****************************************************************
   always_comb begin
      first = PTR_ALL_FIRST;
      last = PTR_BCAST;
      case (step.opt[1:0])
         OPT_ALL: begin
            first = PTR_ALL_FIRST;
            last = PTR_BCAST;
         end
         OPT_BRIGHT: begin
            first = PTR_BRIGHT_FIRST;
            last = PTR_BRIGHT_LAST;
         end
         OPT_GROUP: begin
            first = PTR_GROUP_DUTY;
            last = PTR_GROUP_PERIOD;
         end
         default: begin
            first = PTR_BRIGHT_FIRST;
            last = PTR_GROUP_PERIOD;
         end
      endcase
   end

   // ****************************************************************
   // step: fixed, wrap at range end, or climb to 11h then wrap to 0
   // ****************************************************************
   always_comb begin
      if (!step.opt[2]) begin
         step.nxt = step.ptr;
      end else if (step.ptr == last) begin
         step.nxt = first;
      end else if (step.ptr >= PTR_BCAST) begin
         step.nxt = PTR_ALL_FIRST;
      end else begin
         step.nxt = step.ptr + 5'h01;
      end
   end

endmodule // iad_ptr_step

//--- hdl/iad_front.sv
// bus slave front end: address decode, control byte, pointer stepping
`timescale 1ns/100ps
module iad_front
   import iad_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [6:0] dev_addr_i,
   output logic [4:0] reg_ptr_o,
   output logic reg_rd_o,
   input wire logic [7:0] reg_rdata_i,
   output logic reg_wr_o,
   output logic [4:0] reg_waddr_o,
   output logic [7:0] reg_wdata_o,
   output logic [7:0] primary_mode_o,
   output logic soft_reset_o
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [2:0] scl_sync_q;
   logic [2:0] sda_sync_q;
   logic scl_q;
   logic sda_q;
   logic scl_stable;
   logic sda_stable;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   iad_state_t state_q;
   iad_kind_t kind_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] rx_shift_q;
   logic [7:0] tx_shift_q;
   logic drive_low_q;
   logic rw_q;
   logic mack_ok_q;
   logic [6:0] dev_addr_q;
   logic [7:0] ctrl_q;
   logic [4:0] mode_q;
   logic [7:0] addr_reg_q [N_ADDR_REGS];
   logic [N_ADDR_REGS-1:0] addr_match;
   logic addr_rst;
   logic ack_now;
   logic byte_done;
   logic data_wr_evt;
   logic ctrl_evt;
   logic tx_load;
   logic ptr_adv;
   logic ptr_mapped;
   logic [1:0] addr_idx;
   logic [7:0] rd_data;
   logic soft_rst_q;
   logic [4:0] ptr;

   iad_step_if step ();

   assign ptr = ctrl_q[CTRL_PTR_MSB:0];

   // ****************************************************************
   // pin synchronisers: a change counts when stages two and three agree
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], scl_i};
         sda_sync_q <= {sda_sync_q[1:0], sda_i};
      end
   end

   assign scl_stable = scl_sync_q[1] == scl_sync_q[2];
   assign sda_stable = sda_sync_q[1] == sda_sync_q[2];

   // filtered line levels
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         if (scl_stable) begin
            scl_q <= scl_sync_q[2];
         end
         if (sda_stable) begin
            sda_q <= sda_sync_q[2];
         end
      end
   end

   // ****************************************************************
   // bus events; data moving while the clock is high is start or stop
   // ****************************************************************
   assign scl_rise = scl_stable && scl_sync_q[2] && !scl_q;
   assign scl_fall = scl_stable && !scl_sync_q[2] && scl_q;
   assign bus_start = scl_q && !scl_fall && sda_stable &&
                      !sda_sync_q[2] && sda_q;
   assign bus_stop = scl_q && !scl_fall && sda_stable &&
                     sda_sync_q[2] && !sda_q;

   // address pins are quasi-static straps, sampled every cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dev_addr_q <= 7'h00;
      end else begin
         dev_addr_q <= dev_addr_i;
      end
   end

   // ****************************************************************
   // address compare against group and broadcast addresses
   // ****************************************************************
   for (genvar g = 0; g < N_ADDR_REGS; g++) begin : g_addr
      // entry g sits at pointer 0Eh+g, enabled by mode bit 3-g
      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            addr_reg_q[g] <= ADDR_RST[g];
         end else if (soft_rst_q) begin
            addr_reg_q[g] <= ADDR_RST[g];
         end else if (data_wr_evt && ptr == PTR_GRP1 + 5'(g)) begin
            addr_reg_q[g] <= {rx_shift_q[7:1], 1'b0};
         end
      end
      assign addr_match[g] = mode_q[MODE_GRP1_BIT - g] &&
                             rx_shift_q[7:1] == addr_reg_q[g][7:1];
   end

   // soft reset call is taken only with the write direction
   assign addr_rst = rx_shift_q == SOFT_RESET_CALL;

   // ****************************************************************
   // acknowledge decision for the byte just received
   // ****************************************************************
   always_comb begin
      ack_now = 1'b0;
      case (kind_q)
         K_ADDR: begin
            ack_now = (rx_shift_q[7:1] == dev_addr_q) || (|addr_match) ||
                      addr_rst;
         end
         K_CTRL: begin
            ack_now = 1'b1;
         end
         K_DATA: begin
            ack_now = 1'b1;
         end
         K_RST1: begin
            ack_now = rx_shift_q == SOFT_KEY1;
         end
         K_RST2: begin
            ack_now = rx_shift_q == SOFT_KEY2;
         end
         default: begin
            ack_now = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // byte events
   // ****************************************************************
   assign byte_done = state_q == ST_RX && scl_fall && bit_cnt_q == BYTE_BITS;
   assign ctrl_evt = byte_done && kind_q == K_CTRL;
   assign data_wr_evt = byte_done && kind_q == K_DATA && !rw_q;
   assign tx_load = scl_fall && ((state_q == ST_ACK && rw_q) ||
                    (state_q == ST_MACK && mack_ok_q));
   assign ptr_adv = data_wr_evt || tx_load;
   assign ptr_mapped = ptr <= PTR_FAULT;

   // ****************************************************************
   // transfer state machine
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         drive_low_q <= 1'b0;
      end else if (bus_start) begin
         state_q <= ST_RX;
         bit_cnt_q <= 4'h0;
         drive_low_q <= 1'b0;
      end else if (bus_stop) begin
         state_q <= ST_IDLE;
         drive_low_q <= 1'b0;
      end else begin
         case (state_q)
            ST_RX: begin
               if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_done) begin
                  // hold data low through the acknowledge clock
                  drive_low_q <= ack_now;
                  state_q <= ack_now ? ST_ACK : ST_IDLE;
               end
            end
            ST_ACK: begin
               if (tx_load) begin
                  state_q <= ST_TX;
                  bit_cnt_q <= 4'h0;
                  drive_low_q <= !rd_data[7];
               end else if (scl_fall) begin
                  state_q <= ST_RX;
                  bit_cnt_q <= 4'h0;
                  drive_low_q <= 1'b0;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_q == BYTE_BITS - 4'h1) begin
                     state_q <= ST_MACK;
                     drive_low_q <= 1'b0;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     drive_low_q <= !tx_shift_q[6];
                  end
               end
            end
            ST_MACK: begin
               if (tx_load) begin
                  state_q <= ST_TX;
                  bit_cnt_q <= 4'h0;
                  drive_low_q <= !rd_data[7];
               end else if (scl_fall) begin
                  // master declined the byte: line stays released
                  state_q <= ST_IDLE;
                  drive_low_q <= 1'b0;
               end
            end
            default: begin
               drive_low_q <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // byte kind tracking and soft reset sequence
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         kind_q <= K_ADDR;
         rw_q <= 1'b0;
      end else if (bus_start) begin
         kind_q <= K_ADDR;
         rw_q <= 1'b0;
      end else if (byte_done) begin
         if (!ack_now) begin
            kind_q <= K_ADDR; // abort any pending soft reset
         end else begin
            case (kind_q)
               K_ADDR: begin
                  if (addr_rst) begin
                     kind_q <= K_RST1;
                  end else begin
                     rw_q <= rx_shift_q[0];
                     kind_q <= rx_shift_q[0] ? K_DATA : K_CTRL;
                  end
               end
               K_CTRL: kind_q <= K_DATA;
               K_RST1: kind_q <= K_RST2;
               K_RST2: kind_q <= K_RST_DONE;
               default: kind_q <= kind_q;
            endcase
         end
      end
   end

   // reset pulse only after stop closes a complete call
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= bus_stop && kind_q == K_RST_DONE;
      end
   end

   // ****************************************************************
   // shift registers and master acknowledge sample
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_shift_q <= 8'h00;
      end else if (state_q == ST_RX && scl_rise) begin
         rx_shift_q <= {rx_shift_q[6:0], sda_q};
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_shift_q <= 8'h00;
      end else if (tx_load) begin
         tx_shift_q <= rd_data;
      end else if (state_q == ST_TX && scl_fall) begin
         tx_shift_q <= {tx_shift_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mack_ok_q <= 1'b0;
      end else if (state_q == ST_MACK && scl_rise) begin
         mack_ok_q <= !sda_q;
      end
   end

   // ****************************************************************
   // control register: pointer stepping never touches the options
   // ****************************************************************
   assign step.ptr = ptr;
   assign step.opt = ctrl_q[7:INCR_OPTION_LO];

   iad_ptr_step u_step (
      .step (step)
   );

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_q <= CTRL_RST;
      end else if (soft_rst_q) begin
         ctrl_q <= CTRL_RST;
      end else if (ctrl_evt) begin
         ctrl_q <= rx_shift_q;
      end else if (ptr_adv) begin
         ctrl_q[CTRL_PTR_MSB:0] <= step.nxt;
      end
   end

   // low bits of the primary mode register live here
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_q <= MODE_RST;
      end else if (soft_rst_q) begin
         mode_q <= MODE_RST;
      end else if (data_wr_evt && ptr == PTR_MODE) begin
         mode_q <= rx_shift_q[4:0];
      end
   end

   // ****************************************************************
   // read data: local registers, outer registers, zero when unmapped
   // ****************************************************************
   assign addr_idx = 2'(ptr - PTR_GRP1);

   always_comb begin
      rd_data = 8'h00;
      if (ptr == PTR_MODE) begin
         rd_data = {ctrl_q[7:INCR_OPTION_LO], mode_q};
      end else if (ptr >= PTR_GRP1 && ptr <= PTR_BCAST) begin
         rd_data = addr_reg_q[addr_idx];
      end else if (ptr_mapped) begin
         rd_data = reg_rdata_i;
      end
   end

   // ****************************************************************
   // strobes towards the register file
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_wr_o <= 1'b0;
         reg_waddr_o <= 5'h00;
         reg_wdata_o <= 8'h00;
      end else begin
         reg_wr_o <= data_wr_evt && ptr_mapped;
         if (data_wr_evt) begin
            reg_waddr_o <= ptr;
            reg_wdata_o <= rx_shift_q;
         end
      end
   end

   assign reg_rd_o = tx_load && ptr_mapped;
   assign reg_ptr_o = ptr;
   assign primary_mode_o = {ctrl_q[7:INCR_OPTION_LO], mode_q};
   assign soft_reset_o = soft_rst_q;

   // open drain: the pin only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_o = drive_low_q;

endmodule // iad_front

//--- tb/iad_bus_master.sv
// bus master model driving clock and data toward the slave
`timescale 1ns/100ps
module iad_bus_master (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // high from a start until the matching stop
   logic in_frame = 1'b0;

   // both lines released between frames, so the clock stands still
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // wait on falling edges of the system clock
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // one bit: data moves only while the clock is low, sampled while high
   task automatic bit_x(input logic b, output logic r);
      scl_o = 1'b0;
      tick(2);
      sda_o = b;
      tick(4);
      scl_o = 1'b1;
      tick(1);
      r = sda_i;
      tick(1);
   endtask

   // start when first is 1, stop when first is 0; inside a frame the
   // clock is lowered first so the slave lets go of its ack
   task automatic edge_x(input logic first);
      if (in_frame) begin
         scl_o = 1'b0;
         tick(2);
         sda_o = first;
         tick(4);
         scl_o = 1'b1;
      end
      tick(4);
      sda_o = ~first;
      tick(4);
      in_frame = first;
   endtask

   // address or data byte, most significant bit first, then the ack slot
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   // read byte; acked unless it is the last one wanted
   task automatic rd(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(last, r);
   endtask
endmodule // iad_bus_master

//--- tb/iad_front_asserts.sv
// concurrent checks watching the ports of the bus front end
`timescale 1ns/100ps
module iad_front_asserts (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic sda_oe_o,
   input wire logic [4:0] reg_ptr_o,
   input wire logic reg_rd_o,
   input wire logic reg_wr_o,
   input wire logic [4:0] reg_waddr_o,
   input wire logic [7:0] primary_mode_o,
   input wire logic soft_reset_o
);
   logic [2:0] opt;

   // option bits of the control byte as seen on the mode output
   assign opt = primary_mode_o[7:5];

   // all checks on the system clock, quiet during reset
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   write_ack_held_a: assert property (reg_wr_o |-> sda_oe_o)
      else $error("write strobe without ack on the line");
   read_mapped_a: assert property (reg_rd_o |-> reg_ptr_o <= 5'h13)
      else $error("read strobe on unmapped pointer");
   fixed_ptr_a: assert property (
      reg_wr_o && opt == 3'h0 |=> reg_ptr_o == $past(reg_waddr_o))
      else $error("pointer moved without auto-increment");
   step_up_a: assert property (
      reg_wr_o && opt[2] && reg_waddr_o == 5'h02 |=> reg_ptr_o == 5'h03)
      else $error("pointer did not advance");
   wrap_all_a: assert property (
      reg_wr_o && opt == 3'h4 && reg_waddr_o == 5'h11 |=> reg_ptr_o == 5'h00)
      else $error("all-register wrap wrong");
   wrap_bright_a: assert property (
      reg_wr_o && opt == 3'h5 && reg_waddr_o == 5'h09 |=> reg_ptr_o == 5'h02)
      else $error("brightness wrap wrong");
   wrap_group_a: assert property (
      reg_wr_o && opt == 3'h6 && reg_waddr_o == 5'h0b |=> reg_ptr_o == 5'h0a)
      else $error("group wrap wrong");
   wrap_both_a: assert property (
      reg_wr_o && opt == 3'h7 && reg_waddr_o == 5'h0b |=> reg_ptr_o == 5'h02)
      else $error("brightness and group wrap wrong");
   skip_ref_a: assert property (
      reg_wr_o && opt[2] |=> reg_ptr_o < 5'h12)
      else $error("stepping reached reference or flag register");
   opt_kept_a: assert property (reg_wr_o |=> $stable(opt))
      else $error("option bits changed by stepping");
   soft_reset_a: assert property (
      soft_reset_o |-> ##[0:2] (primary_mode_o == 8'h11 && reg_ptr_o == 5'h00))
      else $error("soft reset did not restore defaults");
endmodule // iad_front_asserts

bind iad_front iad_front_asserts i_chk (
   .clk_i, .rst_b_i, .sda_oe_o, .reg_ptr_o, .reg_rd_o, .reg_wr_o,
   .reg_waddr_o, .primary_mode_o, .soft_reset_o
);

//--- tb/testbench.sv
// self-checking bench for the bus front end
`timescale 1ns/100ps
module testbench;
   import iad_pkg::*;

   typedef struct {
      logic [7:0] addr;
      logic ack;
      logic [7:0] ctrl;
      int n;
      logic [7:0] m;
   } iad_row_t;

   logic clk, rst_b, scl, sda_m, sda_w, sda_oe, rd, wr, srst;
   logic [4:0] ptr, waddr;
   logic [7:0] wdata, mode, rdata;
   logic [12:0] wq[$];
   logic [6:0] dev_addr = 7'h2a;
   int errors = 0;
   int compares = 0;
   int srst_n = 0;
   // address, ack, control byte, data bytes (-1: none), value for 00h
   iad_row_t rows[24] = '{
      '{8'h54, 1, 8'h05, 3, 8'h01}, '{8'h54, 1, 8'h90, 4, 8'h01},
      '{8'h54, 1, 8'ha8, 4, 8'h01}, '{8'h54, 1, 8'hca, 3, 8'h01},
      '{8'h54, 1, 8'heb, 3, 8'h01}, '{8'h54, 1, 8'hec, 9, 8'h01},
      '{8'h54, 1, 8'h94, 2, 8'h01}, '{8'h54, 1, 8'h92, 2, 8'h01},
      '{8'h55, 1, 8'h00, -1, 8'h00}, '{8'h56, 0, 8'h00, -1, 8'h00},
      '{8'h90, 1, 8'h02, 1, 8'h01}, '{8'h91, 1, 8'h00, -1, 8'h00},
      '{8'h92, 0, 8'h00, -1, 8'h00}, '{8'h93, 0, 8'h00, -1, 8'h00},
      '{8'h94, 0, 8'h00, -1, 8'h00}, '{8'h95, 0, 8'h00, -1, 8'h00},
      '{8'h98, 0, 8'h00, -1, 8'h00}, '{8'h99, 0, 8'h00, -1, 8'h00},
      '{8'h97, 0, 8'h00, -1, 8'h00}, '{8'h54, 1, 8'h00, 1, 8'h09},
      '{8'h92, 1, 8'h03, 1, 8'h09}, '{8'h93, 1, 8'h00, -1, 8'h00},
      '{8'h54, 1, 8'h00, 1, 8'h01}, '{8'h92, 0, 8'h00, -1, 8'h00}
   };

   // wired data line with pull-up; external registers answer at once
   assign sda_w = sda_m & ~sda_oe;
   assign rdata = {3'h7, ptr};

   iad_front i_dut (.clk_i(clk), .rst_b_i(rst_b), .scl_i(scl),
      .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .dev_addr_i(dev_addr),
      .reg_ptr_o(ptr), .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_wr_o(wr),
      .reg_waddr_o(waddr), .reg_wdata_o(wdata), .primary_mode_o(mode),
      .soft_reset_o(srst));
   iad_bus_master i_mst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl),
      .sda_o(sda_m));

   // system clock, 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // record register writes and soft reset pulses
   always @(posedge clk) begin
      if (wr === 1'b1) wq.push_back({waddr, wdata});
      if (srst === 1'b1) srst_n++;
   end

   task automatic check(input string name, input logic [15:0] exp,
      input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // expected pointer after one access
   function automatic logic [4:0] nxt(input logic [7:0] c,
      input logic [4:0] p);
      if (!c[7]) return p;
      if (p >= 5'h11) return 5'h00;
      case (c[6:5])
         2'h1: return (p == 5'h09) ? 5'h02 : p + 5'h01;
         2'h2: return (p == 5'h0b) ? 5'h0a : p + 5'h01;
         2'h3: return (p == 5'h0b) ? 5'h02 : p + 5'h01;
         default: return p + 5'h01;
      endcase
   endfunction

   // data written at a pointer; address registers keep their defaults
   function automatic logic [7:0] dv(input logic [4:0] p, input logic [7:0] m);
      case (p)
         5'h00: return m;
         5'h0e: return 8'h92;
         5'h0f: return 8'h94;
         5'h10: return 8'h98;
         5'h11: return 8'h90;
         default: return {3'h2, p};
      endcase
   endfunction

   task automatic summarize();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // one framed transfer of a table row; reserved codes never sent
   task automatic xfer(input iad_row_t r);
      logic a;
      logic [7:0] d;
      logic [4:0] p;
      logic [12:0] e[$];
      wq.delete();
      i_mst.edge_x(1'b1);
      i_mst.wr(r.addr, a);
      check("address ack", r.ack, a);
      if (a && r.addr[0]) i_mst.rd(1'b1, d);
      if (a && !r.addr[0] && r.n >= 0) begin
         i_mst.wr(r.ctrl, a);
         check("control ack", 1'b1, a);
         p = r.ctrl[4:0];
         for (int i = 0; i < r.n; i++) begin
            if (p <= 5'h13) e.push_back({p, dv(p, r.m)});
            i_mst.wr(dv(p, r.m), a);
            check("data ack", 1'b1, a);
            p = nxt(r.ctrl, p);
         end
         check("option bits", r.ctrl[7:5], mode[7:5]);
         check("pointer", p, ptr);
      end
      i_mst.edge_x(1'b0);
      check("write count", e.size(), wq.size());
      foreach (e[i]) begin
         if (i < wq.size()) check("write", e[i], wq[i]);
      end
   endtask

   // cut a hung run short
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      summarize();
   end

   // main sequence: reset, table, then read, bad key and soft reset
   initial begin
      logic a;
      logic [7:0] d;
      logic [4:0] p;
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      check("mode reset", 8'h11, mode);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      check("pointer reset", 5'h00, ptr);
      foreach (rows[i]) xfer(rows[i]);
      xfer('{8'h54, 1, 8'ha9, 0, 8'h01});
      i_mst.edge_x(1'b1);
      i_mst.wr(8'h55, a);
      p = 5'h09;
      for (int i = 0; i < 3; i++) begin
         i_mst.rd(i == 2, d);
         check("read data", {3'h7, p}, d);
         p = nxt(8'ha9, p);
      end
      check("line released", 1'b0, sda_oe);
      i_mst.edge_x(1'b0);
      for (int k = 0; k < 2; k++) begin
         i_mst.edge_x(1'b1);
         i_mst.wr(8'h96, a);
         check("reset call ack", 1'b1, a);
         i_mst.wr((k == 1) ? 8'ha5 : 8'ha4, a);
         check("first key ack", k == 1, a);
         if (k == 1) begin
            i_mst.wr(8'h5a, a);
            check("second key ack", 1'b1, a);
         end
         i_mst.edge_x(1'b0);
      end
      i_mst.tick(4);
      check("reset pulses", 1, srst_n);
      check("mode after reset", 8'h11, mode);
      // moved strap address: new address answered, old one refused
      dev_addr = 7'h15;
      xfer('{8'h2a, 1, 8'h00, -1, 8'h00});
      xfer('{8'h54, 0, 8'h00, -1, 8'h00});
      summarize();
   end
endmodule // testbench
